// *** hw/dbr_pkg.sv ***
// constants and types shared by the debug enclave read check block
package dbr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LEAF   = 8'h00;
  localparam logic [7:0] OFS_SRC_LO = 8'h04;
  localparam logic [7:0] OFS_SRC_HI = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_SEGLIM = 8'h10;
  localparam logic [7:0] OFS_CMD    = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RES_LO = 8'h1C;
  localparam logic [7:0] OFS_RES_HI = 8'h20;
  localparam logic [7:0] OFS_FA_LO  = 8'h24;
  localparam logic [7:0] OFS_FA_HI  = 8'h28;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int CTRL_LMA    = 0;
  localparam int CTRL_CSL    = 1;
  localparam int CTRL_DSUSE  = 2;
  localparam int CTRL_DSOK   = 3;
  localparam int CTRL_CPL_LO = 4;
  localparam int CTRL_W      = 6;
  localparam int CMD_START   = 0;
  localparam logic [5:0]  CTRL_RST  = 6'h0C;
  localparam logic [31:0] LEAF_DBG_READ = 32'h0000_0004;
  localparam logic [31:0] SEGLIM_RST    = 32'hFFFF_FFFF;
  localparam logic [11:0] PAGE_OFS_MASK = 12'hFFF;
  localparam logic [11:0] TCS_LIMIT_DEF = 12'h048;
  localparam logic [32:0] NARROW_LAST   = 33'h0_0000_0003;
  localparam int          VA_BITS_DEF   = 48;
  localparam int          NUM_OPS       = 10;

  // page types as coded by the page cache map
  localparam logic [7:0] PT_CTRL = 8'h00;
  localparam logic [7:0] PT_THRD = 8'h01;
  localparam logic [7:0] PT_REGL = 8'h02;
  localparam logic [7:0] PT_VARR = 8'h03;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOOK  = 2'b01,
    ST_CHECK = 2'b10
  } dbr_state_e;

  typedef enum logic [3:0] {
    C_NONE   = 4'h0, C_CPL    = 4'h1, C_ALIGN = 4'h2,
    C_NOPCC  = 4'h3, C_CONFL  = 4'h4, C_INVAL = 4'h5,
    C_TYPE   = 4'h6, C_TCSLIM = 4'h7, C_NODBG = 4'h8,
    C_SEG    = 4'h9, C_CANON  = 4'hA, C_LEAF  = 4'hB
  } dbr_cause_e;

  typedef enum logic [1:0] {
    K_NONE = 2'b00, K_PROT = 2'b01, K_PAGE = 2'b10, K_LEAF = 2'b11
  } dbr_kind_e;

  // answer of the page cache map lookup
  typedef struct packed {
    logic        in_cache;
    logic        valid;
    logic [7:0]  ptype;
    logic        dbg_ok;
    logic [63:0] data;
  } dbr_map_rsp_s;

endpackage

// *** hw/dbr_read_check.sv ***
// debug enclave read leaf: checks, page cache lookup and ahb registers
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dbr_read_check
  import dbr_pkg::*;
#(
  parameter int          VA_BITS   = VA_BITS_DEF,
  parameter logic [11:0] TCS_LIMIT = TCS_LIMIT_DEF
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  output logic                    map_req,
  output logic [63:0]             map_addr,
  input  wire logic               map_ack,
  input  wire dbr_map_rsp_s       map_rsp,
  input  wire logic [NUM_OPS-1:0] op_busy,
  output logic                    busy,
  output logic                    done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dbr_state_e   st_r;
  dbr_cause_e   cause_r;
  dbr_cause_e   cause_nxt;
  dbr_map_rsp_s rsp_r;
  logic [31:0]  leaf_r;
  logic [63:0]  src_r;
  logic [5:0]   ctrl_r;
  logic [31:0]  seglim_r;
  logic [63:0]  res_r;
  logic [63:0]  fa_r;
  logic [63:0]  addr_r;
  logic         wide_r;
  logic         conf_r;
  logic         done_r;
  logic         wr_r;
  logic         rd_r;
  logic [7:0]   dp_addr_r;
  logic [31:0]  hrdata_r;
  logic         acc;
  logic         wr_go;
  logic         start;
  logic         wide_nxt;
  logic         seg_bad;
  logic         canon;
  logic [32:0]  last_byte;
  dbr_kind_e    kind_r;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  // reads take one wait state so that hrdata comes from a flop and a
  // write in the preceding data phase is already visible
  assign acc       = hsel && hready && htrans[1];
  assign hreadyout = !rd_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign wr_go     = wr_r && (st_r == ST_IDLE);

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        wr_r <= acc && hwrite;
        rd_r <= acc && !hwrite;
        if (acc) begin
          dp_addr_r <= haddr[7:0];
        end
      end else begin
        rd_r <= 1'b0;
      end
    end
  end

  // read mux, sampled during the wait state; unmapped words read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce && rd_r) begin
      unique case (dp_addr_r)
        OFS_LEAF:   hrdata_r <= leaf_r;
        OFS_SRC_LO: hrdata_r <= src_r[31:0];
        OFS_SRC_HI: hrdata_r <= src_r[63:32];
        OFS_CTRL:   hrdata_r <= {26'h000_0000, ctrl_r};
        OFS_SEGLIM: hrdata_r <= seglim_r;
        OFS_STATUS: hrdata_r <= {24'h00_0000, cause_r, kind_r,
                                 done_r, busy};
        OFS_RES_LO: hrdata_r <= res_r[31:0];
        OFS_RES_HI: hrdata_r <= res_r[63:32];
        OFS_FA_LO:  hrdata_r <= fa_r[31:0];
        OFS_FA_HI:  hrdata_r <= fa_r[63:32];
        default:    hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // writes while a read is in flight are dropped, so the operands
  // cannot shift under the checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      leaf_r   <= 32'h0000_0000;
      src_r    <= 64'h0000_0000_0000_0000;
      ctrl_r   <= CTRL_RST;
      seglim_r <= SEGLIM_RST;
    end else if (ce && wr_go) begin
      unique case (dp_addr_r)
        OFS_LEAF:   leaf_r <= hwdata;
        OFS_SRC_LO: src_r[31:0] <= hwdata;
        OFS_SRC_HI: src_r[63:32] <= hwdata;
        OFS_CTRL:   ctrl_r <= hwdata[CTRL_W-1:0];
        OFS_SEGLIM: seglim_r <= hwdata;
        default:    ;
      endcase
    end
  end

  assign start = wr_go && (dp_addr_r == OFS_CMD) && hwdata[CMD_START];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign wide_nxt = ctrl_r[CTRL_LMA] && ctrl_r[CTRL_CSL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_IDLE;
    end else if (ce) begin
      unique case (st_r)
        ST_IDLE: begin
          if (start && leaf_r == LEAF_DBG_READ) begin
            st_r <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (map_ack) begin
            st_r <= ST_CHECK;
          end
        end
        ST_CHECK: st_r <= ST_IDLE;
        default:  st_r <= ST_IDLE;
      endcase
    end
  end

  // operand snapshot; width comes from the mode and nothing else
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wide_r <= 1'b0;
      addr_r <= 64'h0000_0000_0000_0000;
    end else if (ce && start) begin
      wide_r <= wide_nxt;
      addr_r <= wide_nxt ? src_r : {32'h0000_0000, src_r[31:0]};
    end
  end

  // lookup answer and concurrent operations, held for the check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_r  <= '0;
      conf_r <= 1'b0;
    end else if (ce && st_r == ST_LOOK && map_ack) begin
      rsp_r  <= map_rsp;
      conf_r <= |op_busy;
    end
  end

  assign map_req  = (st_r == ST_LOOK);
  assign map_addr = addr_r;
  assign busy     = (st_r != ST_IDLE);
  assign done     = done_r;

  // ---------------------------------------------------------------
  // checks, first failure wins
  // ---------------------------------------------------------------
  assign last_byte = {1'b0, addr_r[31:0]} + NARROW_LAST;
  assign seg_bad   = !ctrl_r[CTRL_DSUSE] || !ctrl_r[CTRL_DSOK] ||
                     (last_byte > {1'b0, seglim_r});
  assign canon     = (&addr_r[63:VA_BITS-1]) || !(|addr_r[63:VA_BITS-1]);

  // permission bits are not part of the lookup answer at all
  always_comb begin
    cause_nxt = C_NONE;
    if (ctrl_r[CTRL_W-1:CTRL_CPL_LO] != 2'b00) begin
      cause_nxt = C_CPL;
    end else if (wide_r && addr_r[2:0] != 3'b000) begin
      cause_nxt = C_ALIGN;
    end else if (!wide_r && addr_r[1:0] != 2'b00) begin
      cause_nxt = C_ALIGN;
    end else if (!rsp_r.in_cache) begin
      cause_nxt = C_NOPCC;
    end else if (conf_r) begin
      cause_nxt = C_CONFL;
    end else if (!rsp_r.valid) begin
      cause_nxt = C_INVAL;
    end else if (rsp_r.ptype != PT_REGL && rsp_r.ptype != PT_THRD &&
                 rsp_r.ptype != PT_VARR) begin
      cause_nxt = C_TYPE;
    end else if (rsp_r.ptype == PT_THRD &&
                 (addr_r[11:0] & PAGE_OFS_MASK) >= TCS_LIMIT) begin
      cause_nxt = C_TCSLIM;
    end else if (rsp_r.ptype != PT_VARR && !rsp_r.dbg_ok) begin
      cause_nxt = C_NODBG;
    end else if (!wide_r && seg_bad) begin
      cause_nxt = C_SEG;
    end else if (wide_r && !canon) begin
      cause_nxt = C_CANON;
    end
  end

  // ---------------------------------------------------------------
  // status and result
  // ---------------------------------------------------------------
  // done is cleared only by a start, which cannot meet a check cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= C_NONE;
      kind_r  <= K_NONE;
      done_r  <= 1'b0;
      fa_r    <= 64'h0000_0000_0000_0000;
    end else if (ce) begin
      if (start) begin
        done_r  <= (leaf_r != LEAF_DBG_READ);
        cause_r <= (leaf_r != LEAF_DBG_READ) ? C_LEAF : C_NONE;
        kind_r  <= (leaf_r != LEAF_DBG_READ) ? K_LEAF : K_NONE;
      end else if (st_r == ST_CHECK) begin
        done_r  <= 1'b1;
        cause_r <= cause_nxt;
        unique case (cause_nxt)
          C_NONE: kind_r <= K_NONE;
          C_NOPCC, C_INVAL, C_TYPE: begin
            kind_r <= K_PAGE;
            fa_r   <= addr_r;
          end
          default: kind_r <= K_PROT;
        endcase
      end
    end
  end

  // result written only when every check passed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_r <= 64'h0000_0000_0000_0000;
    end else if (ce && st_r == ST_CHECK && cause_nxt == C_NONE) begin
      if (wide_r) begin
        res_r <= rsp_r.data;
      end else begin
        res_r[31:0] <= rsp_r.data[31:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking dbr_cb @(posedge hclk iff ce);
  endclocking
  default disable iff (!hresetn);

  sequence good_start_s;
    start && leaf_r == LEAF_DBG_READ;
  endsequence

  sequence check_s;
    st_r == ST_CHECK && ctrl_r[CTRL_W-1:CTRL_CPL_LO] == 2'b00;
  endsequence

  leaf_gate_a: assert property (
    start && leaf_r != LEAF_DBG_READ |=> !map_req && cause_r == C_LEAF)
    else $error("wrong leaf started a lookup");

  wide_mode_a: assert property (
    good_start_s |=> wide_r ==
      ($past(ctrl_r[CTRL_LMA]) && $past(ctrl_r[CTRL_CSL])))
    else $error("wide flag does not follow mode bits");

  align_wide_a: assert property (
    check_s and (wide_r && addr_r[2:0] != 3'b000)
      |=> cause_r == C_ALIGN && kind_r == K_PROT)
    else $error("misaligned wide read not faulted");

  align_narrow_a: assert property (
    check_s and (!wide_r && addr_r[1:0] != 2'b00)
      |=> cause_r == C_ALIGN && kind_r == K_PROT)
    else $error("misaligned narrow read not faulted");

  outside_pcc_a: assert property (
    check_s and (addr_r[1:0] == 2'b00 && !wide_r && !rsp_r.in_cache)
      |=> kind_r == K_PAGE && fa_r == $past(addr_r))
    else $error("address outside cache not page faulted");

  conflict_gp_a: assert property (
    st_r == ST_LOOK && map_ack && |op_busy |=> cause_nxt != C_NONE)
    else $error("conflict not reported");

  conflict_seen_a: assert property (
    st_r == ST_LOOK && map_ack && |op_busy ##1 check_s
      |=> cause_r != C_NONE)
    else $error("read overlapped a page map operation");

  fault_hold_a: assert property (
    st_r == ST_CHECK && cause_nxt != C_NONE |=> $stable(res_r))
    else $error("result changed on a faulting read");

  wide_load_a: assert property (
    st_r == ST_CHECK && cause_nxt == C_NONE && wide_r
      |=> res_r == $past(rsp_r.data))
    else $error("wide result not loaded");

  narrow_keep_a: assert property (
    st_r == ST_CHECK && cause_nxt == C_NONE && !wide_r
      |=> res_r[63:32] == $past(res_r[63:32]))
    else $error("narrow read touched upper half");

  seq_len_a: assert property (
    good_start_s |=> map_req ##[1:1000] st_r == ST_IDLE && done_r)
    else $error("read did not finish in bound");

  tcs_limit_a: assert property (
    st_r == ST_CHECK && cause_nxt == C_NONE && rsp_r.ptype == PT_THRD
      |-> addr_r[11:0] < TCS_LIMIT)
    else $error("thread page offset beyond limit returned data");

  debug_gate_a: assert property (
    st_r == ST_CHECK && cause_nxt == C_NONE
      |-> rsp_r.dbg_ok || rsp_r.ptype == PT_VARR)
    else $error("non-debug enclave page returned data");

  valid_entry_a: assert property (
    st_r == ST_CHECK && cause_nxt == C_NONE
      |-> rsp_r.in_cache && rsp_r.valid && !conf_r)
    else $error("invalid or busy entry returned data");

endmodule

`default_nettype wire

// *** verification/dbr_map_model.sv ***
// behavioural page cache map that answers the block's lookups
`timescale 1ns/1ps
`default_nettype none

module dbr_map_model
  import dbr_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         map_req,
  input  wire logic [63:0]  map_addr,
  input  wire dbr_map_rsp_s cfg,
  input  wire logic [3:0]   dly,
  output logic              map_ack,
  output dbr_map_rsp_s      map_rsp,
  output logic [63:0]       seen_addr
);
  logic [3:0] wait_r;

  // address of the last answered lookup, for the bench to judge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_addr <= 64'h0000_0000_0000_0000;
    end else if (map_req && map_ack) begin
      seen_addr <= map_addr;
    end
  end

  // -------------------------------------------------------------
  // one pulse per request, after dly idle cycles
  // -------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r  <= 4'h0;
      map_ack <= 1'b0;
    end else if (map_ack || !map_req) begin
      wait_r  <= 4'h0;
      map_ack <= 1'b0;
    end else if (wait_r >= dly) begin
      map_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end

  // answer only valid in the ack cycle; inverted otherwise so stale
  // values can never pass for a real answer
  assign map_rsp = map_ack ? cfg : ~cfg;
endmodule

`default_nettype wire

// *** verification/dbr_read_check_bench.sv ***
// self-checking bench for the debug enclave read check block
`timescale 1ns/1ps
`default_nettype none

module dbr_read_check_bench;
  import dbr_pkg::*;

  localparam logic [11:0] TLIM = 12'h048;
  localparam logic [63:0] D    = 64'hA5C3_0F1E_7788_9922;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic         map_req, map_ack, busy, done;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [63:0]  map_addr, seen_addr;
  logic [9:0]   op_busy;
  logic [3:0]   dly;
  dbr_map_rsp_s cfg, map_rsp;
  int           n_fail, n_tests;

  // -------------------------------------------------------------
  // clock, design and map model
  // -------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  dbr_read_check #(.VA_BITS(48), .TCS_LIMIT(TLIM)) DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .map_req(map_req),
    .map_addr(map_addr), .map_ack(map_ack), .map_rsp(map_rsp),
    .op_busy(op_busy), .busy(busy), .done(done));

  dbr_map_model MAP (.hclk(hclk), .hresetn(hresetn),
    .map_req(map_req), .map_addr(map_addr), .cfg(cfg), .dly(dly),
    .map_ack(map_ack), .map_rsp(map_rsp), .seen_addr(seen_addr));

  // -------------------------------------------------------------
  // shared helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // ready is looked at on the falling edge, half a cycle before the rising one; inputs only move on rising edges
  task automatic wt(output logic [31:0] q);
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wt(q);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt(q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk("register", e, q);
  endtask

  function automatic dbr_map_rsp_s mk(logic [7:0] pt, logic dbg);
    mk = '{1'b1, 1'b1, pt, dbg, D};
  endfunction

  // full leaf run, then status and done are judged
  task automatic run(input logic [31:0] lf, input logic [63:0] a,
                     input logic [5:0] ct, input dbr_map_rsp_s r,
                     input logic [1:0] k, input logic [3:0] c);
    logic [31:0] q;
    int          i;
    logic [63:0] ea;
    cfg <= r;
    wr(OFS_LEAF, lf);
    wr(OFS_SRC_LO, a[31:0]);
    wr(OFS_SRC_HI, a[63:32]);
    wr(OFS_CTRL, {26'h0, ct});
    wr(OFS_CMD, 32'h1);
    q = 32'h0;
    for (i = 0; i < 40 && q[1:0] !== 2'b10; i++) begin
      xfer(1'b0, OFS_STATUS, 32'h0, q);
    end
    chk("status", {c, k, 2'b10}, q[7:0]);
    chk("done", 1'b1, done);
    chk("busy", 1'b0, busy);
    chk("hresp", 1'b0, hresp);
    // narrow mode looks up only the low word of the pointer
    ea = (ct[CTRL_LMA] && ct[CTRL_CSL]) ? a : {32'h0, a[31:0]};
    if (lf == LEAF_DBG_READ) begin
      chk("lookup address", ea, seen_addr);
    end
  endtask

  task automatic res(input logic [63:0] e);
    rk(OFS_RES_LO, e[31:0]);
    rk(OFS_RES_HI, e[63:32]);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    rk(OFS_CTRL, 32'h0C);
    rk(OFS_SEGLIM, SEGLIM_RST);
    rk(OFS_RES_LO, 32'h0);
    rk(8'h3C, 32'h0);
  endtask

  task automatic t_width();
    dbr_map_rsp_s r;
    r = mk(PT_REGL, 1'b1);
    run(LEAF_DBG_READ, 64'h1000, 6'h0F, r, K_NONE, C_NONE);
    res(D);
    r.data = ~D;
    dly <= 4'h3;
    run(LEAF_DBG_READ, 64'h2004, 6'h0D, r, K_NONE, C_NONE);
    res({D[63:32], ~D[31:0]});
    dly <= 4'h0;
  endtask

  task automatic t_align();
    dbr_map_rsp_s r;
    r = mk(PT_REGL, 1'b1);
    r.in_cache = 1'b0;
    run(LEAF_DBG_READ, 64'h1004, 6'h0F, r, K_PROT, C_ALIGN);
    res({D[63:32], ~D[31:0]});
    run(LEAF_DBG_READ, 64'h1002, 6'h0C, r, K_PROT, C_ALIGN);
    run(LEAF_DBG_READ, 64'h1004, 6'h0C, r, K_PAGE, C_NOPCC);
    rk(OFS_FA_LO, 32'h1004);
  endtask

  task automatic t_conf();
    int i;
    for (i = 0; i < NUM_OPS; i++) begin
      op_busy <= 10'h1 << i;
      run(LEAF_DBG_READ, 64'h40, 6'h0C, mk(PT_REGL, 1'b1),
          K_PROT, C_CONFL);
    end
    op_busy <= 10'h0;
  endtask

  task automatic t_page();
    dbr_map_rsp_s r;
    r = mk(PT_REGL, 1'b1);
    r.valid = 1'b0;
    run(LEAF_DBG_READ, 64'h5008, 6'h0F, r, K_PAGE, C_INVAL);
    rk(OFS_FA_LO, 32'h5008);
    run(LEAF_DBG_READ, 64'h6000, 6'h0F, mk(PT_CTRL, 1'b1),
        K_PAGE, C_TYPE);
    run(LEAF_DBG_READ, 64'h6000, 6'h0F, mk(8'h07, 1'b1),
        K_PAGE, C_TYPE);
    run(LEAF_DBG_READ, 64'h7010, 6'h0F, mk(PT_VARR, 1'b0),
        K_NONE, C_NONE);
  endtask

  task automatic t_tcs_dbg();
    run(LEAF_DBG_READ, {52'h3, TLIM}, 6'h0F, mk(PT_THRD, 1'b1),
        K_PROT, C_TCSLIM);
    run(LEAF_DBG_READ, {52'h3, TLIM - 12'h8}, 6'h0F, mk(PT_THRD, 1'b1),
        K_NONE, C_NONE);
    run(LEAF_DBG_READ, 64'h3000, 6'h0F, mk(PT_THRD, 1'b0),
        K_PROT, C_NODBG);
    run(LEAF_DBG_READ, 64'h8000, 6'h0C, mk(PT_REGL, 1'b0),
        K_PROT, C_NODBG);
  endtask

  task automatic t_seg_canon();
    dbr_map_rsp_s r;
    r = mk(PT_REGL, 1'b1);
    wr(OFS_SEGLIM, 32'hFFF);
    run(LEAF_DBG_READ, 64'hFFC, 6'h0C, r, K_NONE, C_NONE);
    run(LEAF_DBG_READ, 64'h1000, 6'h0C, r, K_PROT, C_SEG);
    wr(OFS_SEGLIM, SEGLIM_RST);
    run(LEAF_DBG_READ, 64'h100, 6'h08, r, K_PROT, C_SEG);
    run(LEAF_DBG_READ, 64'h100, 6'h04, r, K_PROT, C_SEG);
    run(LEAF_DBG_READ, 64'h0000_8000_0000_0000, 6'h0F, r,
        K_PROT, C_CANON);
    run(LEAF_DBG_READ, 64'hFFFF_8000_0000_0000, 6'h0F, r,
        K_NONE, C_NONE);
  endtask

  task automatic t_leaf();
    run(32'h5, 64'h100, 6'h0F, mk(PT_REGL, 1'b1), K_LEAF, C_LEAF);
    run(LEAF_DBG_READ, 64'h100, 6'h1F, mk(PT_REGL, 1'b1),
        K_PROT, C_CPL);
    res(D);
  endtask

  // -------------------------------------------------------------
  // verdict and main sequence
  // -------------------------------------------------------------
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles; this bound is generous
  initial begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    test_done();
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    op_busy = 10'h0;
    dly = 4'h0;
    cfg = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_width();
    t_align();
    t_conf();
    t_page();
    t_tcs_dbg();
    t_seg_canon();
    t_leaf();
    test_done();
  end
endmodule

`default_nettype wire
